// ==== hw/ssb_burst_counter.sv ====
// two-bit burst address counter of the burst memory.
// assumes load and advance are never high together.
`timescale 1ns/1ns
module ssb_burst_counter
  import ssb_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic clk_en,
  // control
  input wire logic load,
  input wire logic advance,
  input wire logic [1:0] start_low,
  input wire logic interleave,
  // low address used in this cycle
  output logic [1:0] cur_low
);
  logic [1:0] start_reg, start_next;
  logic [1:0] step_reg, step_next;
  logic order_reg, order_next;

  always_comb
  begin
    start_next = start_reg;
    step_next = step_reg;
    order_next = order_reg;
    if (load)
    begin
      start_next = start_low;
      step_next = SSB_STEP_FIRST;
      order_next = interleave;
    end
    else if (advance)
      step_next = 2'(step_reg + SSB_STEP_ONE); // wraps to start
    // only a0/a1 move
    cur_low = load ? start_low :
              ssb_burst_low(start_reg, step_next, order_reg);
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      start_reg <= SSB_STEP_FIRST;
      step_reg <= SSB_STEP_FIRST;
      order_reg <= 1'b0;
    end
    else if (clk_en)
    begin
      start_reg <= start_next;
      step_reg <= step_next;
      order_reg <= order_next;
    end
  end
endmodule

// ==== hw/ssb_burst_sram.sv ====
// synchronous pipelined burst memory end of the memory bus.
// holds the array, the write lane decode, the read pipeline and the
// burst counter; the array keeps its words through sleep and reset.
// assumes its inputs come from logic on the same clock, so they are
// sampled directly; output enable acts without the clock.
`timescale 1ns/1ns
module ssb_burst_sram
  import ssb_pkg::*;
#(
  parameter int DEPTH = 2 ** SSB_ADDR_W
)
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic clk_en,
  // memory bus
  ssb_bus_if.memory bus,
  // status
  output logic burst_active,
  output logic asleep
);
  // ----------------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------------
  logic [SSB_DATA_W-1:0] mem [DEPTH];

  // ----------------------------------------------------------------------
  // cycle decode
  // ----------------------------------------------------------------------
  logic selected;
  logic proc_start;
  logic ctrl_start;
  logic begin_burst;
  logic deselect;
  logic cont;
  logic advance;
  logic [SSB_LANES-1:0] wr_lanes;
  logic write_now;
  logic read_now;
  logic [1:0] cur_low;
  logic [SSB_ADDR_W-1:0] eff_addr;

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  logic active_reg, active_next;
  logic [SSB_ADDR_W-3:0] base_hi_reg, base_hi_next;
  logic rd_pend_reg, rd_pend_next;
  logic [SSB_ADDR_W-1:0] rd_addr_reg, rd_addr_next;
  logic [SSB_DATA_W-1:0] dout_reg, dout_next;
  logic dout_valid_reg, dout_valid_next;
  logic asleep_reg, asleep_next;

  // ----------------------------------------------------------------------
  // write decode
  // ----------------------------------------------------------------------
  // global write overrides whatever the byte path shows
  function automatic logic [SSB_LANES-1:0] write_lanes(logic gw_n,
    logic bwe_n, logic [SSB_LANES-1:0] sel_n);
    if (!gw_n)
      write_lanes = '1;
    else if (!bwe_n)
      write_lanes = ~sel_n;
    else
      write_lanes = '0;
  endfunction

  always_comb
  begin
    selected = !bus.chip_enable_n && bus.select_high_active &&
               !bus.select_low_active_n;
    // the processor strobe is gated by chip enable
    proc_start = !bus.proc_addr_strobe_n && !bus.chip_enable_n;
    // a processor start takes precedence over a controller start
    ctrl_start = !bus.ctrl_addr_strobe_n && !proc_start;
    begin_burst = (proc_start || ctrl_start) && selected;
    deselect = (proc_start || ctrl_start) && !selected;
    cont = !proc_start && !ctrl_start && active_reg;
    advance = cont && !bus.burst_advance_n; // held high keeps word
    wr_lanes = write_lanes(bus.global_write_n, bus.byte_write_enable_n,
                           bus.byte_select_n);
    // a processor start is always a read
    if (proc_start)
      wr_lanes = '0;
    // sleep ignores every synchronous input
    if (bus.sleep_request)
    begin
      begin_burst = 1'b0;
      deselect = 1'b0;
      cont = 1'b0;
      advance = 1'b0;
      wr_lanes = '0;
    end
    write_now = (begin_burst || cont) && (wr_lanes != '0);
    read_now = (begin_burst || cont) && (wr_lanes == '0);
  end

  // ----------------------------------------------------------------------
  // burst counter
  // ----------------------------------------------------------------------
  ssb_burst_counter u_counter (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .clk_en(clk_en),
    .load(begin_burst),
    .advance(advance),
    .start_low(bus.addr[1:0]),
    .interleave(bus.burst_order_select),
    .cur_low(cur_low)
  );

  // ----------------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------------
  always_comb
  begin
    eff_addr = begin_burst ? bus.addr : {base_hi_reg, cur_low};
    active_next = active_reg;
    base_hi_next = base_hi_reg;
    if (begin_burst)
    begin
      active_next = 1'b1;
      base_hi_next = bus.addr[SSB_ADDR_W-1:2];
    end
    else if (deselect)
      active_next = 1'b0;
    // input registers are dropped in sleep; a new strobe is needed
    if (bus.sleep_request)
      active_next = 1'b0;
    rd_pend_next = read_now;
    rd_addr_next = read_now ? eff_addr : rd_addr_reg;
    // output register stage, data appear one clock later
    dout_next = rd_pend_reg ? mem[rd_addr_reg] : dout_reg;
    dout_valid_next = rd_pend_reg && !bus.sleep_request;
    asleep_next = bus.sleep_request;
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      active_reg <= 1'b0;
      base_hi_reg <= '0;
      rd_pend_reg <= 1'b0;
      rd_addr_reg <= '0;
      dout_reg <= '0;
      dout_valid_reg <= 1'b0;
      asleep_reg <= 1'b0;
    end
    else if (clk_en)
    begin
      active_reg <= active_next;
      base_hi_reg <= base_hi_next;
      rd_pend_reg <= rd_pend_next;
      rd_addr_reg <= rd_addr_next;
      dout_reg <= dout_next;
      dout_valid_reg <= dout_valid_next;
      asleep_reg <= asleep_next;
    end
  end

  // ----------------------------------------------------------------------
  // lane writes
  // ----------------------------------------------------------------------
  // storage has no reset, like the array it models
  always_ff @(posedge clk_sys)
  begin
    if (clk_en && write_now)
    begin
      for (int i = 0; i < SSB_LANES; i++)
      begin
        if (wr_lanes[i])
          mem[eff_addr][i*SSB_LANE_W +: SSB_LANE_W] <=
            bus.dq[i*SSB_LANE_W +: SSB_LANE_W];
      end
    end
  end

  // ----------------------------------------------------------------------
  // pins and status
  // ----------------------------------------------------------------------
  // output enable is asynchronous; sleep floats the pins at once
  assign bus.mem_dq_oe_n = !(dout_valid_reg && !bus.output_enable_n &&
                             !bus.sleep_request);
  assign bus.mem_dq_out = dout_reg;
  // burst_active drops on a deselect cycle or on sleep
  assign burst_active = active_reg;
  assign asleep = asleep_reg;
endmodule

// ==== hw/ssb_sram_controller.sv ====
// controller end of the memory bus: runs four-word bursts and sleep on
// orders written through a small register port.
// assumes the memory shares clk_sys and answers reads two cycles after
// the strobe cycle.
//
// Local design decisions: the placing of the registers and strobed register access.
`timescale 1ns/1ns
module ssb_sram_controller
  import ssb_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic clk_en,
  // static burst order, high for interleaved
  input wire logic interleave_mode,
  // register port
  input wire logic [SSB_REG_W-1:0] reg_addr,
  input wire logic [SSB_DATA_W-1:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [SSB_DATA_W-1:0] reg_rdata,
  // memory bus
  ssb_bus_if.controller bus
);
  ssb_ctrl_state_type state_reg, state_next;
  logic [SSB_WAIT_W-1:0] wait_reg, wait_next;
  logic [2:0] cyc_reg, cyc_next;
  logic wr_reg, wr_next;
  logic proc_reg, proc_next;
  logic [SSB_ADDR_W-1:0] addr_reg, addr_next;
  logic [SSB_LANES-1:0] bytes_reg, bytes_next;
  logic sleep_reg, sleep_next;
  logic order_reg, order_next;
  logic [SSB_DATA_W-1:0] data_reg [SSB_LANES];
  logic [SSB_DATA_W-1:0] data_next [SSB_LANES];
  logic [SSB_DATA_W-1:0] rdata_reg, rdata_next;
  logic cap;

  // ----------------------------------------------------------------------
  // sequencing and register port
  // ----------------------------------------------------------------------
  always_comb
  begin
    state_next = state_reg;
    wait_next = 4'(wait_reg + 1'b1);
    cyc_next = 3'(cyc_reg + 1'b1);
    wr_next = wr_reg;
    proc_next = proc_reg;
    addr_next = addr_reg;
    bytes_next = bytes_reg;
    sleep_next = sleep_reg;
    order_next = order_reg;
    data_next = data_reg;
    rdata_next = '0;
    cap = (state_reg == SSB_ST_ACCESS) && !wr_reg &&
          (cyc_reg >= SSB_CYC_READ_FIRST);
    case (state_reg)
      SSB_ST_POWER_UP:
      begin
        // deselected while the order input settles
        order_next = interleave_mode;
        if (wait_reg == 4'(SSB_ORDER_CONFIG_SETUP_CYC - 1))
          state_next = SSB_ST_IDLE;
      end
      SSB_ST_IDLE:
      begin
        if (sleep_reg)
        begin
          state_next = SSB_ST_SLEEP;
          wait_next = '0;
        end
        else if (reg_write && reg_addr == SSB_REG_CMD &&
                 reg_wdata[SSB_CMD_START_BIT])
        begin
          state_next = SSB_ST_ACCESS;
          cyc_next = SSB_CYC_FIRST;
          wr_next = reg_wdata[SSB_CMD_WRITE_BIT];
          proc_next = reg_wdata[SSB_CMD_PROC_BIT];
        end
      end
      SSB_ST_ACCESS:
      begin
        if ((wr_reg && cyc_reg == SSB_CYC_LAST_ISSUE) ||
            cyc_reg == SSB_CYC_READ_LAST)
          state_next = SSB_ST_IDLE;
      end
      SSB_ST_SLEEP:
      begin
        // at least the minimum pulse, then until software releases it
        if (wait_reg >= 4'(SSB_SLEEP_MIN_PULSE_CYC - 1))
        begin
          wait_next = wait_reg;
          if (!sleep_reg)
          begin
            state_next = SSB_ST_RECOVER;
            wait_next = '0;
          end
        end
      end
      SSB_ST_RECOVER:
      begin
        if (wait_reg == 4'(SSB_SLEEP_RECOVERY_CYC - 1))
          state_next = SSB_ST_IDLE;
      end
      default:
        state_next = SSB_ST_IDLE;
    endcase
    if (reg_write)
    begin
      case (reg_addr)
        SSB_REG_ADDR: addr_next = reg_wdata[SSB_ADDR_W-1:0];
        SSB_REG_BYTES: bytes_next = reg_wdata[SSB_LANES-1:0];
        SSB_REG_SLEEP: sleep_next = reg_wdata[0];
        default:
        begin
          if (reg_addr[SSB_REG_W-1] && reg_addr[SSB_REG_W-2:2] == '0)
            data_next[reg_addr[1:0]] = reg_wdata;
        end
      endcase
    end
    // a captured read word wins over a software write to the same slot
    if (cap)
      data_next[2'(cyc_reg - SSB_CYC_READ_FIRST)] = bus.dq;
    if (reg_read)
    begin
      case (reg_addr)
        SSB_REG_CMD: rdata_next[SSB_CMD_PROC_BIT:SSB_CMD_WRITE_BIT] =
          {proc_reg, wr_reg};
        SSB_REG_ADDR: rdata_next[SSB_ADDR_W-1:0] = addr_reg;
        SSB_REG_BYTES: rdata_next[SSB_LANES-1:0] = bytes_reg;
        SSB_REG_SLEEP: rdata_next[0] = sleep_reg;
        SSB_REG_STATUS:
        begin
          rdata_next[SSB_STATUS_BUSY_BIT] = (state_reg != SSB_ST_IDLE);
          rdata_next[SSB_STATUS_ASLEEP_BIT] = (state_reg == SSB_ST_SLEEP);
        end
        default:
        begin
          if (reg_addr[SSB_REG_W-1] && reg_addr[SSB_REG_W-2:2] == '0)
            rdata_next = data_reg[reg_addr[1:0]];
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_reg <= SSB_ST_POWER_UP;
      wait_reg <= '0;
      cyc_reg <= SSB_CYC_FIRST;
      wr_reg <= 1'b0;
      proc_reg <= 1'b0;
      addr_reg <= '0;
      bytes_reg <= SSB_BYTES_RESET;
      sleep_reg <= 1'b0;
      order_reg <= 1'b0;
      data_reg <= '{default: '0};
      rdata_reg <= '0;
    end
    else if (clk_en)
    begin
      state_reg <= state_next;
      wait_reg <= wait_next;
      cyc_reg <= cyc_next;
      wr_reg <= wr_next;
      proc_reg <= proc_next;
      addr_reg <= addr_next;
      bytes_reg <= bytes_next;
      sleep_reg <= sleep_next;
      order_reg <= order_next; // frozen after power-up
      data_reg <= data_next;
      rdata_reg <= rdata_next;
    end
  end

  // ----------------------------------------------------------------------
  // bus drive, decoded from registered state
  // ----------------------------------------------------------------------
  logic acc;
  logic first;
  logic issue;
  logic all_bytes;
  always_comb
  begin
    acc = (state_reg == SSB_ST_ACCESS);
    first = acc && cyc_reg == SSB_CYC_FIRST;
    issue = acc && cyc_reg <= SSB_CYC_LAST_ISSUE;
    all_bytes = (bytes_reg == '1);
  end
  assign bus.addr = addr_reg;
  assign bus.chip_enable_n = !issue;
  assign bus.select_high_active = 1'b1;
  assign bus.select_low_active_n = 1'b0;
  // reads may use either strobe; writes start by controller strobe only
  assign bus.proc_addr_strobe_n = !(first && proc_reg && !wr_reg);
  // outside a burst the controller strobe with chip enable high deselects
  assign bus.ctrl_addr_strobe_n = issue && !first;
  assign bus.burst_advance_n = !(issue && !first);
  assign bus.global_write_n = !(issue && wr_reg && all_bytes);
  assign bus.byte_write_enable_n = !(issue && wr_reg && !all_bytes);
  assign bus.byte_select_n = ~bytes_reg;
  assign bus.output_enable_n = !(acc && !wr_reg);
  assign bus.sleep_request = (state_reg == SSB_ST_SLEEP);
  assign bus.burst_order_select = order_reg;
  assign bus.ctrl_dq_out = data_reg[cyc_reg[1:0]];
  assign bus.ctrl_dq_oe_n = !(issue && wr_reg);
  assign reg_rdata = rdata_reg;
endmodule

// ==== include/ssb_bus_if.sv ====
// memory bus between the burst memory and its controller.
// assumes both ends on one clock; the shared data wire is resolved here.
`timescale 1ns/1ns
interface ssb_bus_if;
  import ssb_pkg::*;
  logic [SSB_ADDR_W-1:0] addr;
  logic chip_enable_n;
  logic select_high_active;
  logic select_low_active_n;
  logic proc_addr_strobe_n;
  logic ctrl_addr_strobe_n;
  logic burst_advance_n;
  logic global_write_n;
  logic byte_write_enable_n;
  logic [SSB_LANES-1:0] byte_select_n;
  logic output_enable_n;
  logic sleep_request;
  logic burst_order_select;
  logic [SSB_DATA_W-1:0] ctrl_dq_out;
  logic ctrl_dq_oe_n;
  logic [SSB_DATA_W-1:0] mem_dq_out;
  logic mem_dq_oe_n;
  logic [SSB_DATA_W-1:0] dq;
  // undriven wire reads as zero
  assign dq = !mem_dq_oe_n ? mem_dq_out :
              (!ctrl_dq_oe_n ? ctrl_dq_out : '0);
  modport memory (
    input addr, chip_enable_n, select_high_active, select_low_active_n,
    input proc_addr_strobe_n, ctrl_addr_strobe_n, burst_advance_n,
    input global_write_n, byte_write_enable_n, byte_select_n,
    input output_enable_n, sleep_request, burst_order_select, dq,
    output mem_dq_out, mem_dq_oe_n
  );
  modport controller (
    output addr, chip_enable_n, select_high_active, select_low_active_n,
    output proc_addr_strobe_n, ctrl_addr_strobe_n, burst_advance_n,
    output global_write_n, byte_write_enable_n, byte_select_n,
    output output_enable_n, sleep_request, burst_order_select,
    output ctrl_dq_out, ctrl_dq_oe_n,
    input dq
  );
endinterface

// ==== include/ssb_pkg.sv ====
// shared constants, timing counts, burst order function and controller
// states for the synchronous burst memory and its controller.
// assumes a single 100 MHz clock shared by both ends.
package ssb_pkg;
  // ----------------------------------------------------------------------
  // widths
  // ----------------------------------------------------------------------
  localparam int SSB_ADDR_W = 17;
  localparam int SSB_LANES = 4;
  localparam int SSB_LANE_W = 9;
  localparam int SSB_DATA_W = SSB_LANES * SSB_LANE_W;
  localparam int SSB_WAIT_W = 4;
  localparam int SSB_REG_W = 4;
  // ----------------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------------
  localparam int SSB_CLK_PERIOD_NS = 10;
  localparam int SSB_SLEEP_MIN_PULSE_NS = 100;
  localparam int SSB_SLEEP_RECOVERY_TIME_NS = 100;
  localparam int SSB_ORDER_CONFIG_SETUP_NS = 20;
  function automatic int ssb_min_cycles(int ns);
    int c;
    c = (ns + SSB_CLK_PERIOD_NS - 1) / SSB_CLK_PERIOD_NS;
    ssb_min_cycles = (c < 1) ? 1 : c;
  endfunction
  localparam int SSB_SLEEP_MIN_PULSE_CYC =
    ssb_min_cycles(SSB_SLEEP_MIN_PULSE_NS);
  localparam int SSB_SLEEP_RECOVERY_CYC =
    ssb_min_cycles(SSB_SLEEP_RECOVERY_TIME_NS);
  localparam int SSB_ORDER_CONFIG_SETUP_CYC =
    ssb_min_cycles(SSB_ORDER_CONFIG_SETUP_NS);
  // ----------------------------------------------------------------------
  // burst sequencing and controller bus cycles
  // ----------------------------------------------------------------------
  localparam logic [1:0] SSB_STEP_FIRST = 2'h0;
  localparam logic [1:0] SSB_STEP_ONE = 2'h1;
  localparam logic [2:0] SSB_CYC_FIRST = 3'h0;
  localparam logic [2:0] SSB_CYC_LAST_ISSUE = 3'h3;
  localparam logic [2:0] SSB_CYC_READ_FIRST = 3'h2;
  localparam logic [2:0] SSB_CYC_READ_LAST = 3'h5;
  function automatic logic [1:0] ssb_burst_low(logic [1:0] start,
    logic [1:0] step, logic interleave);
    ssb_burst_low = interleave ? (start ^ step) : 2'(start + step);
  endfunction
  // ----------------------------------------------------------------------
  // controller register map (word indices) and fields
  // ----------------------------------------------------------------------
  localparam logic [SSB_REG_W-1:0] SSB_REG_CMD = 4'h0;
  localparam logic [SSB_REG_W-1:0] SSB_REG_ADDR = 4'h1;
  localparam logic [SSB_REG_W-1:0] SSB_REG_BYTES = 4'h2;
  localparam logic [SSB_REG_W-1:0] SSB_REG_SLEEP = 4'h3;
  localparam logic [SSB_REG_W-1:0] SSB_REG_STATUS = 4'h4;
  localparam logic [SSB_REG_W-1:0] SSB_REG_DATA0 = 4'h8;
  localparam int SSB_CMD_START_BIT = 0;
  localparam int SSB_CMD_WRITE_BIT = 1;
  localparam int SSB_CMD_PROC_BIT = 2;
  localparam int SSB_STATUS_BUSY_BIT = 0;
  localparam int SSB_STATUS_ASLEEP_BIT = 1;
  localparam logic [SSB_LANES-1:0] SSB_BYTES_RESET = 4'hF;
  typedef enum {
    SSB_ST_POWER_UP,
    SSB_ST_IDLE,
    SSB_ST_ACCESS,
    SSB_ST_SLEEP,
    SSB_ST_RECOVER
  } ssb_ctrl_state_type;
endpackage

// ==== sim/ssb_bus_asserts.sv ====
// checks on the memory bus between the burst memory and its controller.
// assumes one clock and an active low asynchronous reset.
`timescale 1ns/1ns
module ssb_bus_asserts
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // memory bus
  input wire logic chip_enable_n,
  input wire logic proc_addr_strobe_n,
  input wire logic ctrl_addr_strobe_n,
  input wire logic burst_advance_n,
  input wire logic global_write_n,
  input wire logic byte_write_enable_n,
  input wire logic output_enable_n,
  input wire logic sleep_request,
  input wire logic burst_order_select,
  input wire logic ctrl_dq_oe_n,
  input wire logic mem_dq_oe_n
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);
  // ----------------------------------------------------------------------
  // burst starts
  // ----------------------------------------------------------------------
  sequence rd_go;
    !chip_enable_n && !output_enable_n && (!proc_addr_strobe_n ||
      (!ctrl_addr_strobe_n && global_write_n && byte_write_enable_n));
  endsequence
  sequence wr_go;
    !chip_enable_n && !ctrl_addr_strobe_n &&
      (!global_write_n || !byte_write_enable_n);
  endsequence
  pin_gate_a: assert property (!mem_dq_oe_n |->
    !output_enable_n && !sleep_request) else $error("memory drove dq");
  read_data_a: assert property (rd_go |-> ##2 (!mem_dq_oe_n)[*4])
    else $error("read words not driven two cycles on");
  read_burst_a: assert property (rd_go |=> (!burst_advance_n &&
    !chip_enable_n && proc_addr_strobe_n && ctrl_addr_strobe_n)[*3]
    ##1 chip_enable_n[*2]) else $error("read burst steps wrong");
  write_burst_a: assert property (wr_go |=>
    (!burst_advance_n && !ctrl_dq_oe_n)[*3] ##1 ctrl_dq_oe_n)
    else $error("write burst steps wrong");
  write_start_a: assert property (wr_go or (!chip_enable_n &&
    !proc_addr_strobe_n) |-> !(!proc_addr_strobe_n &&
    (!global_write_n || !byte_write_enable_n)))
    else $error("write started by processor strobe");
  sleep_pulse_a: assert property ($rose(sleep_request) |->
    sleep_request[*5] ##1 sleep_request[*5]) else $error("sleep too short");
  sleep_recover_a: assert property ($fell(sleep_request) |->
    chip_enable_n[*5] ##1 chip_enable_n[*5]) else $error("recovery short");
  power_up_a: assert property ($rose(rst_n) |->
    chip_enable_n[*3]) else $error("access too soon after reset");
  order_static_a: assert property (!chip_enable_n |->
    $stable(burst_order_select)) else $error("order select moved");
endmodule

// ==== sim/sync_burst_sram_control_tb_top.sv ====
// bench: controller and burst memory joined by the bus, driven through
// the controller's register port and compared with a word model.
// assumes the package and the bus interface are compiled first.
`timescale 1ns/1ns
module sync_burst_sram_control_tb_top;
  import ssb_pkg::*;
  logic clk_sys;
  logic rst_n;
  logic interleave_mode;
  logic [SSB_REG_W-1:0] reg_addr;
  logic [SSB_DATA_W-1:0] reg_wdata;
  logic reg_write;
  logic reg_read;
  logic [SSB_DATA_W-1:0] reg_rdata;
  logic mem_asleep;
  logic mem_active;
  logic clk_en;
  logic [SSB_DATA_W-1:0] rd_val;
  logic [SSB_DATA_W-1:0] model_mem [int];
  int bad_count;
  int comparisons;
  ssb_bus_if bus ();
  ssb_burst_sram ssb_burst_sram_inst (.clk_sys(clk_sys), .rst_n(rst_n),
    .clk_en(clk_en), .bus(bus), .burst_active(mem_active),
    .asleep(mem_asleep));
  ssb_sram_controller ssb_sram_controller_inst (.clk_sys(clk_sys),
    .rst_n(rst_n), .clk_en(clk_en), .interleave_mode(interleave_mode),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
    .reg_read(reg_read), .reg_rdata(reg_rdata), .bus(bus));
  ssb_bus_asserts ssb_bus_asserts_inst (.clk_sys(clk_sys), .rst_n(rst_n),
    .chip_enable_n(bus.chip_enable_n),
    .proc_addr_strobe_n(bus.proc_addr_strobe_n),
    .ctrl_addr_strobe_n(bus.ctrl_addr_strobe_n),
    .burst_advance_n(bus.burst_advance_n),
    .global_write_n(bus.global_write_n),
    .byte_write_enable_n(bus.byte_write_enable_n),
    .output_enable_n(bus.output_enable_n),
    .sleep_request(bus.sleep_request),
    .burst_order_select(bus.burst_order_select),
    .ctrl_dq_oe_n(bus.ctrl_dq_oe_n), .mem_dq_oe_n(bus.mem_dq_oe_n));
  // ----------------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------------
  task automatic check(string what, logic [35:0] seen, logic [35:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic reg_wr(logic [3:0] a, logic [35:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'h1;
    @(posedge clk_sys);
    reg_write <= 1'h0;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic reg_rd(logic [3:0] a);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_read <= 1'h1;
    @(posedge clk_sys);
    reg_read <= 1'h0;
    #1;
    rd_val = reg_rdata;
  endtask
  task automatic wait_stat(int b, logic v);
    for (int i = 0; i < 60; i++)
    begin
      reg_rd(SSB_REG_STATUS);
      if (rd_val[b] === v)
        return;
    end
    check("status wait", 36'(rd_val[b]), 36'(v));
    complete_run();
  endtask
  // data registers always get fresh junk so stale words cannot match
  task automatic burst(int a, logic wr, logic prc, logic [3:0] be);
    logic [35:0] w [4];
    logic [35:0] m;
    int ad;
    reg_wr(SSB_REG_BYTES, 36'(be));
    for (int k = 0; k < 4; k++)
    begin
      w[k] = 36'({$urandom(), $urandom()});
      reg_wr(SSB_REG_DATA0 + 4'(k), w[k]);
    end
    reg_wr(SSB_REG_ADDR, 36'(a));
    reg_wr(SSB_REG_CMD, {33'h0, prc, wr, 1'h1});
    wait_stat(SSB_STATUS_BUSY_BIT, 1'h0);
    check("burst ended", 36'(mem_active), 36'h0);
    for (int k = 0; k < 4; k++)
    begin
      ad = interleave_mode ? (a ^ k) : ((a & ~3) | ((a + k) & 3));
      if (wr)
      begin
        m = model_mem[ad];
        for (int l = 0; l < 4; l++)
          if (be[l])
            m[9*l +: 9] = w[k][9*l +: 9];
        model_mem[ad] = m;
      end
      else
      begin
        reg_rd(SSB_REG_DATA0 + 4'(k));
        check("burst word", rd_val, model_mem[ad]);
      end
    end
  endtask
  // ----------------------------------------------------------------------
  // clock and main sequence
  // ----------------------------------------------------------------------
  initial
  begin
    clk_sys = 1'h0;
    forever #5 clk_sys = ~clk_sys;
  end
  initial
  begin
    int a;
    rst_n = 1'h0;
    interleave_mode = 1'h0;
    reg_addr = '0;
    reg_wdata = '0;
    reg_write = 1'h0;
    reg_read = 1'h0;
    clk_en = 1'h1;
    void'($urandom(21667));
    for (int md = 0; md < 2; md++)
    begin
      @(posedge clk_sys);
      rst_n <= 1'h0;
      interleave_mode <= md[0];
      repeat (10) @(posedge clk_sys);
      rst_n <= 1'h1;
      reg_rd(SSB_REG_BYTES);
      check("bytes reset", rd_val, 36'hF);
      reg_rd(4'h5);
      check("unmapped read", rd_val, 36'h0);
      for (int t = 0; t < 4; t++)
      begin
        a = int'(17'($urandom()));
        burst(a, 1'h1, 1'h0, 4'hF);
        burst(a, 1'h0, t[0], 4'hF);
        burst(a ^ t, 1'h1, 1'h0, 4'(1 + $urandom() % 14));
        burst(a, 1'h0, ~t[0], 4'hF);
      end
      $display("burst test in order mode %0d done", md);
      // a write offered while the clock enable is low must be lost
      @(posedge clk_sys);
      clk_en <= 1'h0;
      reg_wr(SSB_REG_SLEEP, 36'h1);
      @(posedge clk_sys);
      clk_en <= 1'h1;
      reg_rd(SSB_REG_SLEEP);
      check("frozen write", rd_val, 36'h0);
      $display("freeze test in order mode %0d done", md);
      reg_wr(SSB_REG_SLEEP, 36'h1);
      wait_stat(SSB_STATUS_ASLEEP_BIT, 1'h1);
      check("memory asleep", 36'(mem_asleep), 36'h1);
      reg_wr(SSB_REG_SLEEP, 36'h0);
      wait_stat(SSB_STATUS_ASLEEP_BIT, 1'h0);
      repeat (SSB_SLEEP_RECOVERY_CYC + 2) @(posedge clk_sys);
      wait_stat(SSB_STATUS_BUSY_BIT, 1'h0);
      burst(a, 1'h0, 1'h0, 4'hF);
      $display("sleep test in order mode %0d done", md);
    end
    complete_run();
  end
endmodule
